// file: pkg/acs_pkg.sv
// Constants, types and helpers of the converter control and status block
// Assumes one 50 MHz clock and a 32-bit classic Wishbone register bus
// How it works
// RULE1: Done flag bit 7 sets at conversion end, clears on result read or control write; the code lets a completion in the same cycle win over the clear
// RULE2: Power bit 5 switches converter off at 0, on at 1; software only
// RULE3: Software waits about 30 us after power on before trusting results
// RULE4: Select field bits 2 to 0 picks analog input n for code n
// RULE5: Input count and code-to-pin mapping are parameters, not fixed at eight
// RULE6: Read-only 8-bit result register holds latest value, bit 7 most significant
// RULE7: Bit 4 of the control register always reads as zero
// RULE8: Software writes zero to bits 6 and 3; hardware ignores them, reads zero
// RULE9: Once powered and stable, conversions of the selected input repeat back to back
// RULE10: Each conversion lasts 64 clocks, the first 31.5 of them sampling; the code samples for the first 32
// RULE11: Any control write aborts the conversion, clears done and restarts at once; the code keeps done set if a conversion completes in that cycle
// RULE12: Conversion completion raises no interrupt; software polls the done flag
package acs_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS      = 20;
  localparam int unsigned STAB_TIME_NS       = 30000;
  localparam int unsigned STAB_CYCLES        = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYCLES        = 64;
  localparam int unsigned SAMPLE_HALF_CYCLES = 63;
  localparam int unsigned SAMPLE_CYCLES      = (SAMPLE_HALF_CYCLES + 1) / 2;
  localparam int unsigned RESULT_BITS        = 8;
  localparam int unsigned BIT_CYCLES         = (CONV_CYCLES - SAMPLE_CYCLES) / RESULT_BITS;
  localparam int unsigned CNT_W              = $clog2(CONV_CYCLES);

  // Analog inputs
  localparam int unsigned SEL_W           = 3;
  localparam int unsigned NUM_INPUTS_DEF  = 8;
  localparam logic [23:0] CHANNEL_MAP_DEF = 24'hFAC688;

  // Register indices, byte address is four times the index
  localparam logic [7:0] RESULT_IDX     = 8'h70;
  localparam logic [7:0] CSR_IDX        = 8'h71;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h72;
  localparam logic [7:0] IRQ_MASK_IDX   = 8'h73;

  // Control and status fields
  localparam int unsigned DONE_BIT  = 7;
  localparam int unsigned POWER_BIT = 5;
  localparam int unsigned SEL_LSB   = 0;
  localparam logic [7:0]  RSV_MASK  = 8'h58;

  // Interrupt fields
  localparam int unsigned IRQ_W           = 2;
  localparam int unsigned IRQ_STABLE_BIT  = 0;
  localparam int unsigned IRQ_OVERRUN_BIT = 1;

  // Reset values
  localparam logic [7:0]       CSR_RST    = 8'h00;
  localparam logic [7:0]       RESULT_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST    = 2'h0;
  localparam logic [7:0]       TRIAL_MSB  = 8'h80;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} acs_state_t;

  // Word address match for one register index
  function automatic logic reg_hit(input logic [31:0] adr, input logic [7:0] idx);
    return adr[31:2] == {22'h000000, idx};
  endfunction

endpackage

// file: pkg/acs_conv_if.sv
// Link between the control logic and the approximation sequencer
// Assumes both ends run on the same clock
interface acs_conv_if;
  logic                   run;
  logic                   start;
  logic                   comp;
  logic                   done;
  logic                   sampling;
  logic [7:0]             result;
  logic [7:0]             trial;

  modport ctrl (output run, start, comp, input done, sampling, result, trial);
  modport eng  (input run, start, comp, output done, sampling, result, trial);
endinterface

// file: logic/acs_stab_timer.sv
// Stabilisation timer of the converter after power on
// Assumes power_on is a registered level on the same clock
module acs_stab_timer
  import acs_pkg::*;
#(
  parameter int unsigned COUNT = STAB_CYCLES
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic power_on,
  output logic      stable
);
  localparam int unsigned CW = $clog2(COUNT + 1);

  logic [CW-1:0] cnt;

  // Counts settling time, restarts on every power down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt    <= '0;
      stable <= 1'b0;
    end else if (!power_on) begin
      cnt    <= '0;
      stable <= 1'b0;
    end else if (cnt == CW'(COUNT - 1)) begin
      stable <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule

// file: logic/acs_sar_engine.sv
// Successive approximation sequencer: sample phase then one bit per slot
// Assumes comp is high while the held input is at or above the trial code
module acs_sar_engine
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control side
  acs_conv_if.eng   conv
);
  localparam logic [CNT_W-1:0] LAST_SAMPLE = CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] LAST_CONV   = CNT_W'(CONV_CYCLES - 1);

  acs_state_t       state;
  acs_state_t       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [7:0]       mask;
  logic             slot_end;
  logic [7:0]       decided;

  // Sequencing of sample and approximation phases
  always_comb begin
    next_state = state;
    next_cnt   = cnt + 1'b1;
    if (!conv.run) begin
      next_state = ST_IDLE;
      next_cnt   = '0;
    end else if (conv.start || state == ST_IDLE) begin
      next_state = ST_SAMPLE;  // [RULE9] [RULE11]
      next_cnt   = '0;
    end else begin
      case (state)
        ST_SAMPLE:  if (cnt == LAST_SAMPLE) next_state = ST_CONVERT;  // [RULE10]
        ST_CONVERT: begin
          if (cnt == LAST_CONV) begin
            next_state = ST_SAMPLE;  // [RULE9]
            next_cnt   = '0;
          end
        end
        default:    next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Sample and hold control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) conv.sampling <= 1'b0;
    else        conv.sampling <= (next_state == ST_SAMPLE);  // [RULE10]
  end

  assign slot_end = (state == ST_CONVERT) &&
                    ((int'(cnt) - SAMPLE_CYCLES) % BIT_CYCLES == BIT_CYCLES - 1);
  assign decided  = conv.comp ? conv.trial : (conv.trial & ~mask);

  // Bit decisions and result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv.trial  <= TRIAL_MSB;
      mask        <= TRIAL_MSB;
      conv.result <= RESULT_RST;
      conv.done   <= 1'b0;
    end else begin
      conv.done <= 1'b0;
      if (!conv.run || conv.start || state != ST_CONVERT) begin
        conv.trial <= TRIAL_MSB;
        mask       <= TRIAL_MSB;
      end else if (slot_end) begin
        conv.trial <= decided | (mask >> 1);
        mask       <= mask >> 1;
        if (mask == 8'h01) begin
          conv.result <= decided;
          conv.done   <= 1'b1;  // [RULE10]
        end
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] samp_len;
  logic [7:0] conv_len;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_len <= 8'h00;
      conv_len <= 8'h00;
    end else begin
      samp_len <= (conv.start || !conv.sampling) ? 8'h00 : samp_len + 8'h01;
      conv_len <= conv.sampling ? 8'h00 : conv_len + 8'h01;
    end
  end

  chk_sample_len: assert property ($fell(conv.sampling) && conv.run && !$past(conv.start)  // [RULE10]
    |-> samp_len == 8'(SAMPLE_CYCLES)) else $error("sample phase length wrong");
  chk_conv_len: assert property (conv.done  // [RULE10]
    |-> conv_len == 8'(CONV_CYCLES - SAMPLE_CYCLES)) else $error("conversion length wrong");
  chk_continuous: assert property (conv.done && conv.run  // [RULE9]
    |-> conv.sampling ##1 conv.sampling) else $error("no back to back conversion");
  chk_off_idle: assert property (!conv.run  // [RULE2]
    |=> !conv.sampling ##1 !conv.done) else $error("converter active while off");
endmodule

// file: logic/acs_top.sv
// Control and status logic of an 8-bit approximation converter
// Assumes a classic Wishbone master and an external mux, DAC and comparator
module acs_top
  import acs_pkg::*;
#(
  parameter int unsigned NUM_INPUTS  = NUM_INPUTS_DEF,
  parameter logic [23:0] CHANNEL_MAP = CHANNEL_MAP_DEF,
  parameter int unsigned STAB_COUNT  = STAB_CYCLES
)(
  // Clock and reset
  input  wire logic                  MCLK,
  input  wire logic                  RST_N,
  // Wishbone slave
  input  wire logic [31:0]           ADR_I,
  input  wire logic [31:0]           DAT_I,
  output logic      [31:0]           DAT_O,
  input  wire logic                  WE_I,
  input  wire logic [3:0]            SEL_I,
  input  wire logic                  STB_I,
  input  wire logic                  CYC_I,
  output logic                       ACK_O,
  // Analog front end
  output logic      [NUM_INPUTS-1:0] INPUT_ENABLE,
  output logic                       CONV_POWER,
  output logic                       SAMPLE_HOLD,
  output logic      [7:0]            DAC_CODE,
  input  wire logic                  COMP_IN,
  // Interrupt
  output logic                       IRQ
);

  acs_conv_if conv ();

  logic             converter_power_on;
  logic [SEL_W-1:0] input_select;
  logic             done_flag;
  logic [7:0]       result_reg;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic             stable;
  logic             stable_d;
  logic             fresh;

  logic             req;
  logic             acc;
  logic             wr_lane0;
  logic             csr_wr;
  logic             res_rd;
  logic             res_clr;
  logic             stat_wr;
  logic             mask_wr;
  logic             ev_stable;
  logic             ev_overrun;
  logic [IRQ_W-1:0] next_status;
  logic [7:0]       csr_byte;
  logic [31:0]      rd_word;

  // Pin enable for one select code
  function automatic logic [NUM_INPUTS-1:0] pin_enable(input logic [SEL_W-1:0] code);
    logic [SEL_W-1:0]      pin;
    logic [NUM_INPUTS-1:0] en;
    pin = CHANNEL_MAP[int'(code) * SEL_W +: SEL_W];  // [RULE5]
    en  = '0;
    if (int'(pin) < NUM_INPUTS) en[pin] = 1'b1;
    return en;
  endfunction

  // Bus decode
  assign req      = CYC_I && STB_I;
  assign acc      = req && ACK_O;
  assign wr_lane0 = acc && WE_I && SEL_I[0];
  assign csr_wr   = wr_lane0 && reg_hit(ADR_I, CSR_IDX);
  assign stat_wr  = wr_lane0 && reg_hit(ADR_I, IRQ_STATUS_IDX);
  assign mask_wr  = wr_lane0 && reg_hit(ADR_I, IRQ_MASK_IDX);
  assign res_rd   = acc && !WE_I && reg_hit(ADR_I, RESULT_IDX);
  assign res_clr  = res_rd && !fresh;

  // Bus answer, one cycle after the request
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) ACK_O <= 1'b0;
    else        ACK_O <= req && !ACK_O;
  end

  // Control byte as software sees it
  always_comb begin
    csr_byte                          = 8'h00;  // [RULE7] [RULE8]
    csr_byte[DONE_BIT]                = done_flag;
    csr_byte[POWER_BIT]               = converter_power_on;
    csr_byte[SEL_LSB +: SEL_W]        = input_select;
  end

  // Read multiplexer, unmapped words read zero
  always_comb begin
    rd_word = 32'h00000000;
    if (reg_hit(ADR_I, RESULT_IDX))     rd_word[7:0]       = result_reg;  // [RULE6]
    if (reg_hit(ADR_I, CSR_IDX))        rd_word[7:0]       = csr_byte;
    if (reg_hit(ADR_I, IRQ_STATUS_IDX)) rd_word[IRQ_W-1:0] = irq_status;
    if (reg_hit(ADR_I, IRQ_MASK_IDX))   rd_word[IRQ_W-1:0] = irq_mask;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      DAT_O <= 32'h00000000;
      fresh <= 1'b0;
    end else if (req && !ACK_O) begin
      DAT_O <= WE_I ? 32'h00000000 : rd_word;
      fresh <= conv.done;
    end else begin
      DAT_O <= 32'h00000000;
      fresh <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      converter_power_on <= CSR_RST[POWER_BIT];
      input_select       <= CSR_RST[SEL_LSB +: SEL_W];
    end else if (csr_wr) begin
      converter_power_on <= DAT_I[POWER_BIT];  // [RULE2]
      input_select       <= DAT_I[SEL_LSB +: SEL_W];  // [RULE4]
    end
  end

  // Abort and restart on every control write
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) conv.start <= 1'b0;
    else        conv.start <= csr_wr;  // [RULE11]
  end

  // Done flag, a completing conversion wins over a clear
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)                    done_flag <= CSR_RST[DONE_BIT];
    else if (conv.done)            done_flag <= 1'b1;  // [RULE1]
    else if (csr_wr || res_clr)    done_flag <= 1'b0;  // [RULE1] [RULE11]
  end

  // Result register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)         result_reg <= RESULT_RST;
    else if (conv.done) result_reg <= conv.result;  // [RULE6]
  end

  // Stabilisation after power on
  acs_stab_timer #(
    .COUNT    (STAB_COUNT)
  ) u_stab (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .power_on (converter_power_on),
    .stable   (stable)
  );

  assign conv.run  = converter_power_on && stable;  // [RULE2] [RULE3]
  assign conv.comp = COMP_IN;

  acs_sar_engine u_engine (
    .clk   (MCLK),
    .rst_n (RST_N),
    .conv  (conv)
  );

  // Analog front end drive
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      INPUT_ENABLE <= '0;
      CONV_POWER   <= 1'b0;
    end else begin
      INPUT_ENABLE <= converter_power_on ? pin_enable(input_select) : '0;  // [RULE4] [RULE5]
      CONV_POWER   <= converter_power_on;  // [RULE2]
    end
  end

  assign SAMPLE_HOLD = conv.sampling;
  assign DAC_CODE    = conv.trial;

  // Events: stable converter and unread result overwritten; completion alone is none
  assign ev_stable  = stable && !stable_d;
  assign ev_overrun = conv.done && done_flag && !(csr_wr || res_clr);  // [RULE12]

  always_comb begin
    next_status = irq_status;
    if (stat_wr) next_status = irq_status & ~DAT_I[IRQ_W-1:0];
    next_status[IRQ_STABLE_BIT]  = next_status[IRQ_STABLE_BIT] | ev_stable;
    next_status[IRQ_OVERRUN_BIT] = next_status[IRQ_OVERRUN_BIT] | ev_overrun;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      stable_d   <= 1'b0;
      irq_status <= IRQ_RST;
    end else begin
      stable_d   <= stable;
      irq_status <= next_status;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)       irq_mask <= IRQ_RST;
    else if (mask_wr) irq_mask <= DAT_I[IRQ_W-1:0];
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) IRQ <= 1'b0;
    else        IRQ <= |(irq_status & irq_mask);
  end

  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence csr_write_on_s;
    csr_wr && DAT_I[POWER_BIT] && stable;
  endsequence

  sequence restart_s;
    conv.start ##1 SAMPLE_HOLD;
  endsequence

  chk_done_sets: assert property (conv.done |=> done_flag)  // [RULE1]
    else $error("done flag not set");
  chk_done_read_clr: assert property (res_rd && !fresh && !conv.done |=> !done_flag)  // [RULE1]
    else $error("done flag not cleared by result read");
  chk_done_write_clr: assert property (csr_wr && !conv.done |=> !done_flag)  // [RULE11]
    else $error("done flag not cleared by control write");
  chk_power_write: assert property (csr_wr  // [RULE2]
    |=> ##1 CONV_POWER == $past(DAT_I[POWER_BIT], 2)) else $error("power bit not applied");
  chk_select_pin: assert property (csr_wr && DAT_I[POWER_BIT]  // [RULE4]
    |=> ##1 INPUT_ENABLE == pin_enable($past(DAT_I[SEL_LSB +: SEL_W], 2)))
    else $error("selected input pin wrong");
  chk_pin_onehot: assert property ($onehot0(INPUT_ENABLE))  // [RULE5]
    else $error("more than one input enabled");
  chk_result_load: assert property (conv.done |=> result_reg == $past(conv.result))  // [RULE6]
    else $error("result not loaded");
  chk_reserved_zero: assert property (ACK_O && !WE_I && reg_hit(ADR_I, CSR_IDX)  // [RULE7]
    |-> (DAT_O[7:0] & RSV_MASK) == 8'h00 && DAT_O[31:8] == 24'h000000)
    else $error("reserved control bits not zero");
  chk_restart_write: assert property (csr_write_on_s |=> restart_s)  // [RULE11]
    else $error("control write did not restart conversion");
  chk_no_done_irq: assert property (conv.done && !done_flag && !ev_stable && !stat_wr  // [RULE12]
    |=> irq_status == $past(irq_status)) else $error("completion raised an interrupt");
  chk_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("acknowledge longer than one cycle");
endmodule

// file: verif/acs_front_model.sv
// Behavioural analog front end: input mux, sample and hold, comparator
// Assumes one-hot input enables and a registered trial code from the block
module acs_front_model
  import acs_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Control from the block
  input  wire logic       power,
  input  wire logic [7:0] enable,
  input  wire logic       sample,
  input  wire logic [7:0] dac,
  // Comparator answer
  output logic            comp,
  // Analog levels as ideal codes
  input  wire logic [7:0] levels [8]
);
  logic [7:0] held;
  logic       junk = 1'b0;

  // Unpowered comparator wanders every cycle
  always_ff @(posedge clk) begin
    junk <= ~junk;
  end

  // Track the enabled input while sampling, hold it afterwards
  always_ff @(posedge clk) begin
    if (sample) begin
      for (int i = 0; i < 8; i++) begin
        if (enable[i]) begin
          held <= levels[i];
        end
      end
    end
  end

  assign comp = power ? (held >= dac) : junk;
endmodule

// file: verif/acs_top_test.sv
// Self-checking bench of the converter control and status block
// Assumes the front end model on the analog side and a Wishbone master here
module acs_top_test
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

  localparam int unsigned STAB  = 4;
  localparam int unsigned LIMIT = 20000;
  typedef struct packed {
    logic [2:0] code;
    logic [7:0] level;
    logic [7:0] res;
    logic [7:0] en;
  } acs_row_t;
  localparam acs_row_t ROWS [8] = '{
    '{3'h0, 8'h00, 8'h00, 8'h01}, '{3'h1, 8'hFF, 8'hFF, 8'h02},
    '{3'h2, 8'h80, 8'h80, 8'h04}, '{3'h3, 8'h7F, 8'h7F, 8'h08},
    '{3'h4, 8'h01, 8'h01, 8'h10}, '{3'h5, 8'h55, 8'h55, 8'h20},
    '{3'h6, 8'hAA, 8'hAA, 8'h40}, '{3'h7, 8'hFE, 8'hFE, 8'h80}};

  logic        mclk  = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] adr   = 32'h0;
  logic [31:0] dat_i = 32'h0;
  logic        we    = 1'b0;
  logic [3:0]  sel   = 4'h0;
  logic        stb   = 1'b0;
  logic        cyc   = 1'b0;
  logic [31:0] dat_o;
  logic        ack;
  logic [7:0]  en;
  logic        power;
  logic        sh;
  logic [7:0]  dac;
  logic        comp;
  logic        irq;
  logic [7:0]  lv [8];
  logic [31:0] rd;
  int          err_count   = 0;
  int          check_count = 0;
  int          cycles      = 0;
  int          hi;
  int          lo;

  acs_top #(.STAB_COUNT(STAB)) dut (
    .MCLK(mclk), .RST_N(rst_n), .ADR_I(adr), .DAT_I(dat_i), .DAT_O(dat_o), .WE_I(we),
    .SEL_I(sel), .STB_I(stb), .CYC_I(cyc), .ACK_O(ack), .INPUT_ENABLE(en),
    .CONV_POWER(power), .SAMPLE_HOLD(sh), .DAC_CODE(dac), .COMP_IN(comp), .IRQ(irq));

  acs_front_model model (
    .clk(mclk), .power(power), .enable(en), .sample(sh), .dac(dac), .comp(comp),
    .levels(lv));

  always #10 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      results();
    end
  end

  task automatic results;
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                    input logic [3:0] s);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= {22'h000000, idx, 2'b00};
    dat_i <= {24'h000000, wd};
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 4'hF);
  endtask

  task automatic rdg(input logic [7:0] idx);
    wb(1'b0, idx, 8'h00, 4'hF);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      rdg(CSR_IDX);
      n++;
    end while (rd[DONE_BIT] !== 1'b1 && n < 60);
    if (n >= 60) begin
      err_count++;
    end
  endtask

  initial begin
    for (int i = 0; i < 8; i++) begin
      lv[i] = ROWS[i].level;
    end
    repeat (4) @(posedge mclk);
    `CHK("dac idle", 8'h80, dac)
    `CHK("power rst", 1'b0, power)
    rst_n <= 1'b1;
    rdg(RESULT_IDX);
    `CHK("result rst", RESULT_RST, rd[7:0])
    rdg(CSR_IDX);
    `CHK("csr rst", CSR_RST, rd[7:0])
    rdg(IRQ_MASK_IDX);
    `CHK("mask rst", 8'h00, rd[7:0])
    foreach (ROWS[i]) begin
      wr(CSR_IDX, {5'h04, ROWS[i].code});
      wait_done();
      rdg(RESULT_IDX);
      `CHK("result", ROWS[i].res, rd[7:0])
      `CHK("enable", ROWS[i].en, en)
      rdg(CSR_IDX);
      `CHK("done cleared", {5'h04, ROWS[i].code}, rd[7:0])
    end
    // Read-only result, reserved bits, byte lanes, holes
    wr(RESULT_IDX, 8'h5A);
    rdg(RESULT_IDX);
    `CHK("result ro", 32'h000000FE, rd)
    wr(CSR_IDX, 8'hB7);
    rdg(CSR_IDX);
    `CHK("csr reserved", 8'h27, rd[7:0])
    wb(1'b1, CSR_IDX, 8'h00, 4'hE);
    rdg(CSR_IDX);
    `CHK("csr lane", 8'h27, rd[7:0])
    rdg(8'h40);
    `CHK("unmapped", 32'h0, rd)
    // Conversion timing, skipping the sample phase cut by the write
    wr(CSR_IDX, 8'h23);
    repeat (2) @(posedge mclk);
    hi = 0;
    while (sh === 1'b1 && hi < 100) begin
      @(posedge mclk);
      hi++;
    end
    hi = 0;
    while (sh !== 1'b1 && hi < 100) begin
      @(posedge mclk);
      hi++;
    end
    hi = 0;
    lo = 0;
    while (sh === 1'b1 && hi < 100) begin
      hi++;
      @(posedge mclk);
    end
    while (sh !== 1'b1 && lo < 100) begin
      lo++;
      @(posedge mclk);
    end
    `CHK("sample len", 32, hi)
    `CHK("conv len", 64, hi + lo)
    // Done clearing by write, abort, continuous run
    wait_done();
    wr(CSR_IDX, 8'h23);
    rdg(CSR_IDX);
    `CHK("done write clr", 8'h23, rd[7:0])
    repeat (30) @(posedge mclk);
    wr(CSR_IDX, 8'h23);
    repeat (50) @(posedge mclk);
    rdg(CSR_IDX);
    `CHK("abort", 8'h23, rd[7:0])
    wait_done();
    rdg(RESULT_IDX);
    repeat (70) @(posedge mclk);
    rdg(CSR_IDX);
    `CHK("continuous", 8'hA3, rd[7:0])
    // Power off
    wr(CSR_IDX, 8'h00);
    repeat (3) @(posedge mclk);
    `CHK("power off", 1'b0, power)
    `CHK("enable off", 8'h00, en)
    hi = 0;
    repeat (100) begin
      @(posedge mclk);
      if (sh === 1'b1) begin
        hi++;
      end
    end
    `CHK("no sampling", 0, hi)
    // Interrupt status, mask, clear
    wr(IRQ_STATUS_IDX, 8'h03);
    wr(CSR_IDX, 8'h20);
    repeat (20) @(posedge mclk);
    rdg(IRQ_STATUS_IDX);
    `CHK("stable flag", 8'h01, rd[7:0])
    `CHK("irq masked", 1'b0, irq)
    wr(IRQ_MASK_IDX, 8'h01);
    repeat (3) @(posedge mclk);
    `CHK("irq set", 1'b1, irq)
    wr(IRQ_STATUS_IDX, 8'h01);
    repeat (3) @(posedge mclk);
    `CHK("irq clear", 1'b0, irq)
    repeat (140) @(posedge mclk);
    rdg(IRQ_STATUS_IDX);
    `CHK("overrun", 8'h02, rd[7:0])
    `CHK("no done irq", 1'b0, irq)
    results();
  end
endmodule
